// ### wkp_pkg.sv
// package for the wake-up pattern 2/3 register bank and matcher
// assumes a 16-bit internal register port at byte addresses, one clock, sync reset
package wkp_pkg;
  localparam int WKP_AW = 8;
  localparam int WKP_DW = 16;
  localparam logic [7:0] WKP_P2_CRC_LOW = 8'h50;
  localparam logic [7:0] WKP_P2_CRC_HIGH = 8'h52;
  localparam logic [7:0] WKP_P2_MASK_1_16 = 8'h54;
  localparam logic [7:0] WKP_P2_MASK_17_32 = 8'h56;
  localparam logic [7:0] WKP_P2_MASK_33_48 = 8'h58;
  localparam logic [7:0] WKP_P2_MASK_49_64 = 8'h5a;
  localparam logic [7:0] WKP_P3_CRC_LOW = 8'h60;
  localparam logic [7:0] WKP_P3_CRC_HIGH = 8'h62;
  localparam logic [7:0] WKP_P3_MASK_1_16 = 8'h64;
  localparam logic [7:0] WKP_P3_MASK_17_32 = 8'h66;
  localparam logic [7:0] WKP_P3_MASK_33_48 = 8'h68;
  localparam logic [7:0] WKP_P3_MASK_49_64 = 8'h6a;
  localparam logic [15:0] WKP_REG_RESET = 16'h0000;
  localparam int WKP_MAX_BYTES = 64;
  localparam logic [31:0] WKP_CRC_INIT = 32'hffffffff;
  localparam logic [31:0] WKP_CRC_POLY_REF = 32'hedb88320;
  localparam logic [31:0] WKP_CRC_XOROUT = 32'hffffffff;
  typedef struct packed {
    logic [31:0] crc;
    logic [63:0] mask;
  } wkp_pat_t;
endpackage

// ### wkp_pat_if.sv
// carries one pattern's settings from the register bank to its matcher
// assumes one clock domain shared by both ends
interface wkp_pat_if;
  import wkp_pkg::*;
  wkp_pat_t pat;
  modport bank (output pat);
  modport match (input pat);
endinterface

// ### wkp_matcher.sv
// one pattern matcher: crc over mask-selected bytes of the first 64 frame bytes
// assumes byte strobes on the device clock, frame_start one cycle before first byte
module wkp_matcher
  import wkp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  wkp_pat_if.match cfg,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_end,
  output logic match_ff
);
  logic [31:0] crc_ff, nxt_crc;
  logic [6:0] idx_ff, nxt_idx;
  logic nxt_match;

  function automatic logic [31:0] wkp_crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ WKP_CRC_POLY_REF) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    nxt_crc = crc_ff;
    nxt_idx = idx_ff;
    nxt_match = 1'b0;
    if (frame_start) begin
      nxt_crc = WKP_CRC_INIT;
      nxt_idx = 7'h00;
    end else if (byte_valid && idx_ff < 7'(WKP_MAX_BYTES)) begin
      // bit n of the mask selects frame byte n+1
      if (cfg.pat.mask[idx_ff[5:0]]) begin
        nxt_crc = wkp_crc_byte(crc_ff, byte_data);
      end
      nxt_idx = idx_ff + 7'h01;
    end
    if (frame_end) begin
      nxt_match = ((crc_ff ^ WKP_CRC_XOROUT) == cfg.pat.crc);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      crc_ff <= WKP_CRC_INIT;
      idx_ff <= 7'h00;
      match_ff <= 1'b0;
    end else begin
      crc_ff <= nxt_crc;
      idx_ff <= nxt_idx;
      match_ff <= nxt_match;
    end
  end

  AST_MATCH_PULSE: assert property (@(posedge clk) disable iff (reset)
    match_ff |-> $past(frame_end)) else $error("match without frame end");
  AST_IDX_LIMIT: assert property (@(posedge clk) disable iff (reset)
    idx_ff <= 7'(WKP_MAX_BYTES)) else $error("byte index past 64");
  AST_UNMASKED_HOLD: assert property (@(posedge clk) disable iff (reset)
    (!frame_start && byte_valid && !cfg.pat.mask[idx_ff[5:0]]) |=> $stable(crc_ff))
    else $error("unmasked byte changed crc");
  // no selected byte leaves the seed in place, which finishes to zero, the crc of nothing
  AST_MATCH_ZERO_MASK: assert property (@(posedge clk) disable iff (reset)
    (frame_end && crc_ff == WKP_CRC_INIT && cfg.pat.crc == 32'h00000000) |=> match_ff)
    else $error("empty selection with zero crc did not match");
endmodule

// ### wkp_regs.sv
// register bank and match logic for wake-up patterns 2 and 3
// assumes the serial register interface decodes into a 16-bit word port, byte enables per lane
module wkp_regs
  import wkp_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [WKP_AW-1:0] reg_addr,
  input wire logic [1:0] reg_be,
  input wire logic [WKP_DW-1:0] reg_wdata,
  output logic [WKP_DW-1:0] reg_rdata_ff,
  output logic reg_rvalid_ff,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic frame_end,
  output logic match2_ff,
  output logic match3_ff
);
  logic [15:0] regs_ff [12];
  logic [15:0] nxt_regs [12];
  logic [15:0] nxt_rdata;
  logic nxt_rvalid;
  localparam logic [7:0] WKP_ADDRS [12] = '{WKP_P2_CRC_LOW, WKP_P2_CRC_HIGH, WKP_P2_MASK_1_16,
    WKP_P2_MASK_17_32, WKP_P2_MASK_33_48, WKP_P2_MASK_49_64, WKP_P3_CRC_LOW, WKP_P3_CRC_HIGH,
    WKP_P3_MASK_1_16, WKP_P3_MASK_17_32, WKP_P3_MASK_33_48, WKP_P3_MASK_49_64};

  // index of the register at an address, 15 when unmapped
  function automatic logic [3:0] wkp_decode(input logic [7:0] a);
    logic [3:0] r;
    r = 4'hf;
    for (int i = 0; i < 12; i++) begin
      if (a == WKP_ADDRS[i]) r = 4'(i);
    end
    return r;
  endfunction

  logic [3:0] sel;
  assign sel = wkp_decode(reg_addr);

  always_comb begin
    for (int i = 0; i < 12; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (reg_wr && sel != 4'hf) begin
      if (reg_be[0]) nxt_regs[sel][7:0] = reg_wdata[7:0];
      if (reg_be[1]) nxt_regs[sel][15:8] = reg_wdata[15:8];
    end
    nxt_rvalid = reg_rd;
    // reserved and unmapped addresses read as zero
    nxt_rdata = 16'h0000;
    if (reg_rd && sel != 4'hf) nxt_rdata = regs_ff[sel];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < 12; i++) begin
        regs_ff[i] <= WKP_REG_RESET;
      end
      reg_rdata_ff <= 16'h0000;
      reg_rvalid_ff <= 1'b0;
    end else begin
      for (int i = 0; i < 12; i++) begin
        regs_ff[i] <= nxt_regs[i];
      end
      reg_rdata_ff <= nxt_rdata;
      reg_rvalid_ff <= nxt_rvalid;
    end
  end

  wkp_pat_if p2_if();
  wkp_pat_if p3_if();
  // low half then high half, masks concatenated with byte 1 at bit 0
  assign p2_if.pat.crc = {regs_ff[1], regs_ff[0]};
  assign p2_if.pat.mask = {regs_ff[5], regs_ff[4], regs_ff[3], regs_ff[2]};
  assign p3_if.pat.crc = {regs_ff[7], regs_ff[6]};
  assign p3_if.pat.mask = {regs_ff[11], regs_ff[10], regs_ff[9], regs_ff[8]};

  wkp_matcher u_m2 (
    .clk(clk),
    .reset(reset),
    .cfg(p2_if.match),
    .frame_start(frame_start),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .frame_end(frame_end),
    .match_ff(match2_ff)
  );
  wkp_matcher u_m3 (
    .clk(clk),
    .reset(reset),
    .cfg(p3_if.match),
    .frame_start(frame_start),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .frame_end(frame_end),
    .match_ff(match3_ff)
  );

  // full-word write to one address, the first step of the crc-high, mask 1-16, pattern 3 mask and g_store checks
  sequence s_wr_full(logic [7:0] a);
    reg_wr && reg_addr == a && reg_be == 2'b11;
  endsequence
  sequence s_wr_p2_low;
    reg_wr && reg_addr == WKP_P2_CRC_LOW && reg_be == 2'b11;
  endsequence
  sequence s_wr_p3_low;
    reg_wr && reg_addr == WKP_P3_CRC_LOW && reg_be == 2'b11;
  endsequence
  // a write to a reserved hole must not alias onto any pattern register
  sequence s_wr_reserved;
    reg_wr && sel == 4'hf;
  endsequence

  AST_P2_LOW_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_p2_low |=> p2_if.pat.crc[15:0] == $past(reg_wdata)) else $error("crc low not stored");
  AST_P2_HIGH_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P2_CRC_HIGH) |=> p2_if.pat.crc[31:16] == $past(reg_wdata))
    else $error("crc high not stored");
  AST_P2_HIGH_LANE: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == WKP_P2_CRC_HIGH && reg_be == 2'b01) |=>
      p2_if.pat.crc[31:16] == {$past(p2_if.pat.crc[31:24]), $past(reg_wdata[7:0])})
    else $error("byte enable not honoured on crc high");
  AST_P3_INDEPENDENT: assert property (@(posedge clk) disable iff (reset)
    s_wr_p3_low |=> $stable(p2_if.pat.crc)) else $error("pattern 3 write hit pattern 2");
  AST_P3_LOW_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_p3_low |=> p3_if.pat.crc[15:0] == $past(reg_wdata)) else $error("p3 crc low not stored");
  AST_P3_HIGH_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P3_CRC_HIGH) |=> p3_if.pat.crc[31:16] == $past(reg_wdata))
    else $error("p3 crc high not stored");
  AST_MASK1_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P2_MASK_1_16) |=> p2_if.pat.mask[15:0] == $past(reg_wdata))
    else $error("mask bytes 1-16 misplaced");
  AST_MASK2_WRITE: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == WKP_P2_MASK_17_32 && reg_be == 2'b11) |=> p2_if.pat.mask[31:16] == $past(reg_wdata))
    else $error("mask bytes 17-32 misplaced");
  AST_MASK3_WRITE: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == WKP_P2_MASK_33_48 && reg_be == 2'b11) |=> p2_if.pat.mask[47:32] == $past(reg_wdata))
    else $error("mask bytes 33-48 misplaced");
  AST_MASK4_WRITE: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == WKP_P2_MASK_49_64 && reg_be == 2'b11) |=> p2_if.pat.mask[63:48] == $past(reg_wdata))
    else $error("mask bytes 49-64 misplaced");
  AST_P3_MASK1_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P3_MASK_1_16) |=> p3_if.pat.mask[15:0] == $past(reg_wdata))
    else $error("p3 mask bytes 1-16 misplaced");
  AST_P3_MASK2_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P3_MASK_17_32) |=> p3_if.pat.mask[31:16] == $past(reg_wdata))
    else $error("p3 mask bytes 17-32 misplaced");
  AST_P3_MASK3_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P3_MASK_33_48) |=> p3_if.pat.mask[47:32] == $past(reg_wdata))
    else $error("p3 mask bytes 33-48 misplaced");
  AST_P3_MASK4_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_full(WKP_P3_MASK_49_64) |=> p3_if.pat.mask[63:48] == $past(reg_wdata))
    else $error("p3 mask bytes 49-64 misplaced");
  AST_P2_MASK_INDEPENDENT: assert property (@(posedge clk) disable iff (reset)
    (reg_wr && reg_addr == WKP_P2_MASK_1_16) |=> $stable(p3_if.pat))
    else $error("pattern 2 write hit pattern 3");
  AST_RESERVED_WRITE: assert property (@(posedge clk) disable iff (reset)
    s_wr_reserved |=> $stable(p2_if.pat) && $stable(p3_if.pat))
    else $error("reserved write changed a pattern");
  AST_READBACK: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && !reg_wr && reg_addr == WKP_P2_MASK_1_16) |=> reg_rvalid_ff && reg_rdata_ff == p2_if.pat.mask[15:0])
    else $error("mask readback wrong");
  AST_RESERVED_READ: assert property (@(posedge clk) disable iff (reset)
    (reg_rd && sel == 4'hf) |=> reg_rvalid_ff && reg_rdata_ff == 16'h0000)
    else $error("reserved read not zero");
  AST_RVALID_PULSE: assert property (@(posedge clk) disable iff (reset)
    reg_rvalid_ff |-> $past(reg_rd)) else $error("read valid without read strobe");
  // checked through reset itself, so no disable here
  AST_RESET_ZERO: assert property (@(posedge clk)
    reset |=> !reg_rvalid_ff && reg_rdata_ff == 16'h0000 && p2_if.pat == '0 && p3_if.pat == '0)
    else $error("reset did not clear the bank");

  for (genvar g = 0; g < 12; g++) begin : g_store
    AST_REG_STORE: assert property (@(posedge clk) disable iff (reset)
      s_wr_full(WKP_ADDRS[g]) |=> regs_ff[g] == $past(reg_wdata))
      else $error("register word not stored");
  end
endmodule

// ### testbench.sv
// self-checking bench for the wake-up pattern 2/3 register bank and matchers
// assumes wkp_pkg, wkp_pat_if, wkp_matcher and wkp_regs are compiled first
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import wkp_pkg::*;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, byte_data = 8'h00;
  logic [1:0] reg_be = 2'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata_ff;
  logic frame_start = 1'b0, byte_valid = 1'b0, frame_end = 1'b0, reg_rvalid_ff, match2_ff, match3_ff;
  logic [15:0] mdl [12];
  logic [7:0] fb [70];
  integer seed = 32'h7160;
  int error_cnt = 0, num_checks = 0;
  always #10 clk = ~clk;
  wkp_regs dut_u (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .frame_start(frame_start), .byte_valid(byte_valid), .byte_data(byte_data), .frame_end(frame_end),
    .match2_ff(match2_ff), .match3_ff(match3_ff));
  function automatic logic [7:0] ad(int i);
    return (i < 6 ? 8'h50 : 8'h54) + 8'(2 * i);
  endfunction
  function automatic logic [15:0] mv(logic [7:0] a);
    mv = 16'h0000;
    for (int i = 0; i < 12; i++) begin
      if (ad(i) == a) mv = mdl[i];
    end
  endfunction
  // bit-serial reference, kept apart from the design's own crc logic
  function automatic logic [31:0] crc(int b, int n);
    logic [31:0] c;
    logic [63:0] m;
    c = 32'hffffffff;
    m = {mdl[b+5], mdl[b+4], mdl[b+3], mdl[b+2]};
    for (int k = 0; k < n && k < 64; k++) begin
      if (m[k]) begin
        c = c ^ {24'h000000, fb[k]};
        for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      end
    end
    return ~c;
  endfunction
  task automatic chk(logic [16:0] g, logic [16:0] e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d, logic [1:0] be);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    reg_be = be;
    @(negedge clk);
    reg_wr = 1'b0;
    for (int i = 0; i < 12; i++) begin
      if (ad(i) == a) mdl[i] = {be[1] ? d[15:8] : mdl[i][15:8], be[0] ? d[7:0] : mdl[i][7:0]};
    end
  endtask
  task automatic rd(logic [7:0] a);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({reg_rvalid_ff, reg_rdata_ff}, {1'b1, mv(a)});
  endtask
  task automatic frame(int n);
    logic e2, e3;
    @(negedge clk);
    frame_start = 1'b1;
    @(negedge clk);
    frame_start = 1'b0;
    for (int k = 0; k < n; k++) begin
      byte_valid = 1'b1;
      byte_data = fb[k];
      @(negedge clk);
    end
    byte_valid = 1'b0;
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
    e2 = crc(0, n) === {mdl[1], mdl[0]};
    e3 = crc(6, n) === {mdl[7], mdl[6]};
    chk({15'h0000, match2_ff, match3_ff}, {15'h0000, e2, e3});
    @(negedge clk);
    chk({15'h0000, match2_ff, match3_ff}, 17'h00000);
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    error_cnt++;
    report_and_stop;
  end
  initial begin
    logic [31:0] c;
    logic [15:0] v;
    for (int i = 0; i < 12; i++) mdl[i] = 16'h0000;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 12; i++) rd(ad(i));
    $display("test reset values done");
    for (int i = 0; i < 12; i++) wr(ad(i), 16'($random(seed)), 2'h3);
    for (int i = 0; i < 12; i++) rd(ad(i));
    wr(8'h52, 16'h5aa5, 2'h1);
    wr(8'h66, 16'ha55a, 2'h2);
    // unmapped writes must leave every register alone and read back as zero
    wr(8'h5c, 16'hffff, 2'h3);
    wr(8'h6c, 16'hffff, 2'h3);
    for (int i = 0; i < 12; i++) rd(ad(i));
    rd(8'h5c);
    rd(8'h6c);
    $display("test register access done");
    // a reset in mid-run must clear contents that are no longer zero
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    for (int i = 0; i < 12; i++) mdl[i] = 16'h0000;
    for (int i = 0; i < 12; i++) rd(ad(i));
    $display("test mid-run reset done");
    // lengths 62..69 straddle the 64-byte limit; odd trials spoil pattern 3,
    // trial 1 leaves pattern 2 with no byte selected and a zero crc
    for (int t = 0; t < 8; t++) begin
      for (int k = 0; k < 70; k++) fb[k] = 8'($random(seed));
      for (int i = 2; i < 12; i++) begin
        v = t == 1 && i < 6 ? 16'h0000 : 16'($random(seed));
        if (i != 6 && i != 7) wr(ad(i), t == 0 ? 16'hffff : v, 2'h3);
      end
      c = crc(0, 62 + t);
      wr(8'h50, c[15:0], 2'h3);
      wr(8'h52, c[31:16], 2'h3);
      c = crc(6, 62 + t) ^ 32'(t % 2);
      wr(8'h60, c[15:0], 2'h3);
      wr(8'h62, c[31:16], 2'h3);
      frame(62 + t);
    end
    $display("test frame match done");
    report_and_stop;
  end
endmodule
